// file: hw/adcseq_top.sv
// Purpose: converter power, clock divider and conversion sequencing
// Assumes: analog core gives a result word at end of conversion
// Notes: registers on a plain strobe port, read data one cycle late
//
// Function
// [RQ1] a start bit pulse low-high-low starts one conversion
// [RQ2] busy flag goes to one once conversion starts
// [RQ3] busy flag clears to zero when conversion finishes
// [RQ4] completion sets the sticky interrupt request flag
// [RQ5] enabled and set request flag drives the interrupt output
// [RQ6] software may poll busy instead of using the interrupt
// [RQ7] conversion clock is system clock divided by two to the select code
// [RQ8] software keeps conversion clock period within recommended range
// [RQ9] analog core powered only while power enable is high
// [RQ10] software waits a settling delay after enabling before starting
// [RQ11] software clears power enable when converter is unused
// [RQ12] conversion is four sample plus twelve convert clock periods
// [RQ13] start ignored while busy; result written before busy clears
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module adcseq_top
  import adcseq_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // analog core
  input wire logic [ADCSEQ_RES_W-1:0] ana_result_i,
  output logic ana_power_o,
  output logic ana_sample_o,
  output logic ana_conv_clk_o,
  // status
  output logic conv_busy_flag_o,
  output logic irq_o
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic conv_start_q;
  logic conv_power_enable_q;
  logic [2:0] conv_clock_divider_select_q;
  logic done_req_q;
  logic done_mask_q;
  logic wr_ctrl0;
  logic wr_ctrl1;
  logic wr_stat;
  logic wr_mask;
  logic start_fall;
  logic [1:0] slot_q;
  logic [1:0] last_slot_q;
  logic [ADCSEQ_RES_W-1:0] mem_rdata;

  assign wr_ctrl0 = reg_wr_i && (reg_addr_i == ADCSEQ_OFF_CTRL0);
  assign wr_ctrl1 = reg_wr_i && (reg_addr_i == ADCSEQ_OFF_CTRL1);
  assign wr_stat = reg_wr_i && (reg_addr_i == ADCSEQ_OFF_STAT);
  assign wr_mask = reg_wr_i && (reg_addr_i == ADCSEQ_OFF_MASK);
  // start acts on the falling edge of the written bit
  assign start_fall = wr_ctrl0 && conv_start_q && !reg_wdata_i[ADCSEQ_BIT_START]; // see [RQ1]

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      conv_start_q <= ADCSEQ_RST_CTRL0[ADCSEQ_BIT_START];
      conv_power_enable_q <= ADCSEQ_RST_CTRL0[ADCSEQ_BIT_PWR];
    end
    else if (ce_i && wr_ctrl0)
    begin
      conv_start_q <= reg_wdata_i[ADCSEQ_BIT_START];
      conv_power_enable_q <= reg_wdata_i[ADCSEQ_BIT_PWR];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      conv_clock_divider_select_q <= ADCSEQ_RST_DIV;
    end
    else if (ce_i && wr_ctrl1)
    begin
      conv_clock_divider_select_q <= reg_wdata_i[ADCSEQ_DIV_LSB +: 3];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      done_mask_q <= ADCSEQ_RST_MASK[ADCSEQ_BIT_DONE];
    end
    else if (ce_i && wr_mask)
    begin
      done_mask_q <= reg_wdata_i[ADCSEQ_BIT_DONE];
    end
  end

  // ----------------------------------------
  // conversion clock divider
  // ----------------------------------------
  adcseq_state_e state_q;
  logic [6:0] div_cnt_q;
  logic [6:0] div_limit;
  logic tick;
  // limit is 2^code - 1; code 000 ticks every cycle
  assign div_limit = 7'((8'h01 << conv_clock_divider_select_q) - 8'h01); // see [RQ7]
  assign tick = (div_cnt_q >= div_limit);

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      div_cnt_q <= 7'h00;
    end
    else if (ce_i)
    begin
      // held while idle so a conversion never starts on a partial period
      if (!conv_power_enable_q || tick || state_q == ADCSEQ_IDLE) // see [RQ12]
      begin
        div_cnt_q <= 7'h00;
      end
      else
      begin
        div_cnt_q <= div_cnt_q + 7'h01; // see [RQ7]
      end
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  logic [3:0] tick_cnt_q;
  logic store_now;
  assign store_now = (state_q == ADCSEQ_STORE);

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_q <= ADCSEQ_IDLE;
      tick_cnt_q <= 4'h0;
    end
    else if (ce_i)
    begin
      if (!conv_power_enable_q)
      begin
        // power-down aborts any conversion
        state_q <= ADCSEQ_IDLE; // see [RQ9]
        tick_cnt_q <= 4'h0;
      end
      else
      begin
        unique case (state_q)
          ADCSEQ_IDLE:
          begin
            // starts while busy never reach here, so they are dropped
            if (start_fall)
            begin
              state_q <= ADCSEQ_SAMPLE; // see [RQ1] see [RQ13]
              tick_cnt_q <= 4'h0;
            end
          end
          ADCSEQ_SAMPLE:
          begin
            if (tick)
            begin
              if (tick_cnt_q == ADCSEQ_SAMPLE_TICKS - 4'h1)
              begin
                state_q <= ADCSEQ_CONVERT; // see [RQ12]
                tick_cnt_q <= 4'h0;
              end
              else
              begin
                tick_cnt_q <= tick_cnt_q + 4'h1;
              end
            end
          end
          ADCSEQ_CONVERT:
          begin
            if (tick)
            begin
              if (tick_cnt_q == ADCSEQ_CONV_TICKS - 4'h1)
              begin
                state_q <= ADCSEQ_STORE; // see [RQ12]
                tick_cnt_q <= 4'h0;
              end
              else
              begin
                tick_cnt_q <= tick_cnt_q + 4'h1;
              end
            end
          end
          ADCSEQ_STORE:
          begin
            state_q <= ADCSEQ_IDLE; // see [RQ3]
          end
        endcase
      end
    end
  end

  // busy rises on start and falls on the same edge as the result store
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      conv_busy_flag_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!conv_power_enable_q || store_now)
      begin
        conv_busy_flag_o <= 1'b0; // see [RQ3] see [RQ13]
      end
      else if (state_q == ADCSEQ_IDLE && start_fall)
      begin
        conv_busy_flag_o <= 1'b1; // see [RQ2]
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ana_power_o <= 1'b0;
      ana_sample_o <= 1'b0;
      ana_conv_clk_o <= 1'b0;
    end
    else if (ce_i)
    begin
      ana_power_o <= conv_power_enable_q; // see [RQ9]
      ana_sample_o <= (state_q == ADCSEQ_SAMPLE);
      ana_conv_clk_o <= tick && (state_q == ADCSEQ_SAMPLE || state_q == ADCSEQ_CONVERT); // see [RQ7]
    end
  end

  // ----------------------------------------
  // result store
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      slot_q <= 2'h0;
      last_slot_q <= 2'h0;
    end
    else if (ce_i && store_now)
    begin
      slot_q <= slot_q + 2'h1;
      last_slot_q <= slot_q;
    end
  end

  adcseq_result_mem u_mem (
    .clk_i(clk_i),
    .ce_i(ce_i),
    .we_i(store_now), // see [RQ13]
    .waddr_i(slot_q),
    .wdata_i(ana_result_i),
    .raddr_i(last_slot_q),
    .rdata_o(mem_rdata)
  );

  // ----------------------------------------
  // interrupt
  // ----------------------------------------
  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      done_req_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (store_now)
      begin
        done_req_q <= 1'b1; // see [RQ4]
      end
      else if (wr_stat && reg_wdata_i[ADCSEQ_BIT_DONE])
      begin
        done_req_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      irq_o <= 1'b0;
    end
    else if (ce_i)
    begin
      irq_o <= done_req_q && done_mask_q; // see [RQ5]
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // result read gives the low byte of the latest stored word
  // data stand one cycle after the strobe only, zero otherwise
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      reg_rdata_o <= 8'h00;
    end
    else if (ce_i)
    begin
      reg_rdata_o <= 8'h00;
      if (reg_rd_i)
      begin
        unique case (reg_addr_i)
          ADCSEQ_OFF_CTRL0:
            reg_rdata_o <= {conv_start_q, conv_busy_flag_o, conv_power_enable_q, 5'h00}; // see [RQ6]
          ADCSEQ_OFF_CTRL1:
            reg_rdata_o <= {5'h00, conv_clock_divider_select_q};
          ADCSEQ_OFF_STAT:
            reg_rdata_o <= {7'h00, done_req_q};
          ADCSEQ_OFF_MASK:
            reg_rdata_o <= {7'h00, done_mask_q};
          ADCSEQ_OFF_RESULT:
            reg_rdata_o <= mem_rdata[7:0];
          default:
            reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end
endmodule : adcseq_top
`default_nettype wire

// file: hw/adcseq_pkg.sv
// Purpose: constants for the converter sequencer
// Assumes: 250 MHz system clock
// Notes: register offsets are word indices on the plain register port
package adcseq_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [3:0] ADCSEQ_OFF_CTRL0 = 4'h0;
  localparam logic [3:0] ADCSEQ_OFF_CTRL1 = 4'h1;
  localparam logic [3:0] ADCSEQ_OFF_STAT = 4'h2;
  localparam logic [3:0] ADCSEQ_OFF_MASK = 4'h3;
  localparam logic [3:0] ADCSEQ_OFF_RESULT = 4'h4;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int ADCSEQ_BIT_START = 7;
  localparam int ADCSEQ_BIT_BUSY = 6;
  localparam int ADCSEQ_BIT_PWR = 5;
  localparam int ADCSEQ_DIV_LSB = 0;
  localparam int ADCSEQ_BIT_DONE = 0;
  // ----------------------------------------
  // reset values and timing
  // ----------------------------------------
  localparam logic [7:0] ADCSEQ_RST_CTRL0 = 8'h00;
  localparam logic [2:0] ADCSEQ_RST_DIV = 3'h0;
  localparam logic [7:0] ADCSEQ_RST_MASK = 8'h00;
  localparam logic [3:0] ADCSEQ_SAMPLE_TICKS = 4'h4;
  localparam logic [3:0] ADCSEQ_CONV_TICKS = 4'hC;
  localparam int ADCSEQ_RES_W = 12;
  localparam int ADCSEQ_SLOTS = 4;
  typedef enum logic [1:0] {
    ADCSEQ_IDLE = 2'b00,
    ADCSEQ_SAMPLE = 2'b01,
    ADCSEQ_CONVERT = 2'b10,
    ADCSEQ_STORE = 2'b11
  } adcseq_state_e;
endpackage : adcseq_pkg

// file: hw/adcseq_result_mem.sv
// Purpose: small result store, registered read
// Assumes: one write port, one read port
// Notes: holds the last few conversion results
`timescale 1ns/1ps
`default_nettype none
module adcseq_result_mem
  import adcseq_pkg::*;
(
  // clock
  input wire logic clk_i,
  input wire logic ce_i,
  // write
  input wire logic we_i,
  input wire logic [1:0] waddr_i,
  input wire logic [ADCSEQ_RES_W-1:0] wdata_i,
  // read
  input wire logic [1:0] raddr_i,
  output logic [ADCSEQ_RES_W-1:0] rdata_o
);
  logic [ADCSEQ_RES_W-1:0] mem_q [ADCSEQ_SLOTS];

  always_ff @(posedge clk_i)
  begin
    if (ce_i && we_i)
    begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (ce_i)
    begin
      rdata_o <= mem_q[raddr_i];
    end
  end
endmodule : adcseq_result_mem
`default_nettype wire

// file: sim/adcseq_properties.sv
// Purpose: port checker for adcseq_top
// Assumes: one clock, ce_i held high by the bench
// Notes: helpers mirror the control bits as written
`timescale 1ns/1ps
`default_nettype none
module adcseq_properties
  import adcseq_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // analog and status
  input wire logic ana_power_o,
  input wire logic ana_sample_o,
  input wire logic conv_busy_flag_o,
  input wire logic irq_o
);
  logic w0, st_q, pw_q, mk_q, irq_wr;
  logic [2:0] dv_q;
  logic [11:0] bc_q;
  assign w0 = reg_wr_i && reg_addr_i == ADCSEQ_OFF_CTRL0;
  assign irq_wr = reg_wr_i && (reg_addr_i == ADCSEQ_OFF_STAT || reg_addr_i == ADCSEQ_OFF_MASK);
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      st_q <= 1'b0;
      pw_q <= 1'b0;
      mk_q <= 1'b0;
      dv_q <= 3'h0;
    end
    else
    begin
      if (w0)
      begin
        st_q <= reg_wdata_i[ADCSEQ_BIT_START];
        pw_q <= reg_wdata_i[ADCSEQ_BIT_PWR];
      end
      if (reg_wr_i && reg_addr_i == ADCSEQ_OFF_MASK)
        mk_q <= reg_wdata_i[ADCSEQ_BIT_DONE];
      if (reg_wr_i && reg_addr_i == ADCSEQ_OFF_CTRL1)
        dv_q <= reg_wdata_i[2:0];
    end
  end
  // busy length, checked when busy drops
  always_ff @(posedge clk_i)
    bc_q <= (sys_rst_i || !conv_busy_flag_o) ? 12'h000 : bc_q + 12'h001;
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_busy_on_start: assert property (w0 && !reg_wdata_i[7] && reg_wdata_i[5] && st_q && pw_q
    && !conv_busy_flag_o |-> ##[1:2] conv_busy_flag_o) else $error("busy did not follow start");
  a_start_unpowered: assert property (w0 && reg_wdata_i[7:5] == 3'h0 && st_q && !pw_q
    && !conv_busy_flag_o |=> !conv_busy_flag_o [*2]) else $error("start taken while off");
  a_power_copy: assert property ($stable(pw_q) |=> ana_power_o == $past(pw_q))
    else $error("power output wrong");
  // power output lags one cycle, so an aborted sample is excluded
  a_sample_in_busy: assert property (ana_sample_o && ana_power_o |-> conv_busy_flag_o)
    else $error("sampling outside busy");
  a_busy_length: assert property ($fell(conv_busy_flag_o) && pw_q |-> bc_q >= (12'h010 << dv_q))
    else $error("conversion too short");
  a_irq_on_done: assert property ($fell(conv_busy_flag_o) && pw_q && mk_q |-> ##[1:3] irq_o)
    else $error("no interrupt after done");
  a_irq_masked: assert property (!mk_q && !$past(mk_q) |-> !irq_o)
    else $error("masked interrupt seen");
  // a clear or mask write takes two edges to reach the output
  a_irq_sticky: assert property (irq_o && !irq_wr && !$past(irq_wr) |=> irq_o)
    else $error("interrupt dropped alone");
  a_unmapped_zero: assert property (reg_rd_i && reg_addr_i > ADCSEQ_OFF_RESULT |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  c_done: cover property ($fell(conv_busy_flag_o));
  c_irq: cover property (irq_o);
  c_start_busy: cover property (w0 && st_q && conv_busy_flag_o);
endmodule : adcseq_properties
bind adcseq_top adcseq_properties u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .ana_power_o(ana_power_o), .ana_sample_o(ana_sample_o), .conv_busy_flag_o(conv_busy_flag_o), .irq_o(irq_o));
`default_nettype wire

// file: sim/tb_adcseq_top.sv
// Purpose: directed bench for adcseq_top
// Assumes: ce_i held high
// Notes: read data checked in the cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module tb_adcseq_top;
  import adcseq_pkg::*;
  logic clk_i, sys_rst_i, reg_wr_i, reg_rd_i, ana_power_o, ana_sample_o, ana_conv_clk_o;
  logic conv_busy_flag_o, irq_o;
  logic [3:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o;
  logic [ADCSEQ_RES_W-1:0] ana_result_i;
  int miscompares = 0, check_count = 0, busy_cyc = 0, pulses = 0, samples = 0;
  adcseq_top dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .ana_result_i(ana_result_i), .ana_power_o(ana_power_o), .ana_sample_o(ana_sample_o),
    .ana_conv_clk_o(ana_conv_clk_o), .conv_busy_flag_o(conv_busy_flag_o), .irq_o(irq_o));
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
    if (conv_busy_flag_o === 1'b1)
    begin
      busy_cyc <= busy_cyc + 1;
      pulses <= pulses + (ana_conv_clk_o === 1'b1 ? 1 : 0);
      samples <= samples + (ana_sample_o === 1'b1 ? 1 : 0);
    end
  // ----
  // tasks
  // ----
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8
  task automatic chkb(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chkb
  // every task that drives a strobe starts on an edge so no strobe is assigned twice in a step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    reg_rd_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_i);
    chk8(reg_rdata_o, e);
  endtask : rd
  task automatic nap(input int n);
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : nap
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic wait_idle;
    int n;
    n = 0;
    while (conv_busy_flag_o !== 1'b0 && n < 4000)
    begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 4000)
    begin
      miscompares++;
      end_sim();
    end
  endtask : wait_idle
  // ----
  // sequence
  // ----
  initial
  begin
    sys_rst_i = 1'b1;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 8'h00;
    ana_result_i = 12'h000;
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(ADCSEQ_OFF_CTRL0, 8'h00);
    rd(ADCSEQ_OFF_CTRL1, 8'h00);
    rd(ADCSEQ_OFF_STAT, 8'h00);
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
    $display("test reset done");
    wr(ADCSEQ_OFF_CTRL0, 8'h80);
    wr(ADCSEQ_OFF_CTRL0, 8'h00);
    nap(4);
    chkb(conv_busy_flag_o, 1'b0);
    chkb(ana_power_o, 1'b0);
    $display("test unpowered done");
    wr(ADCSEQ_OFF_CTRL0, 8'h20);
    nap(8);
    for (int c = 0; c < 8; c++)
    begin
      busy_cyc = 0;
      pulses = 0;
      samples = 0;
      wr(ADCSEQ_OFF_MASK, {7'h00, c[0]});
      // only code 7 stays above the low period bound at this clock
      wr(ADCSEQ_OFF_CTRL1, {5'h00, c[2:0]});
      wr(ADCSEQ_OFF_CTRL0, 8'hA0);
      ana_result_i <= {8'hA5, 1'b0, c[2:0]};
      wr(ADCSEQ_OFF_CTRL0, 8'h20);
      nap(2);
      chkb(conv_busy_flag_o, 1'b1);
      chkb(ana_power_o, 1'b1);
      rd(ADCSEQ_OFF_CTRL0, 8'h60);
      // a second pulse while busy must not restart the count
      wr(ADCSEQ_OFF_CTRL0, 8'hA0);
      wr(ADCSEQ_OFF_CTRL0, 8'h20);
      wait_idle();
      chkb(busy_cyc >= (16 << c) && busy_cyc <= (17 << c) + 4, 1'b1);
      chkb(pulses == 16, 1'b1);
      chkb(samples == (4 << c), 1'b1);
      nap(3);
      chkb(irq_o, c[0]);
      rd(ADCSEQ_OFF_RESULT, {4'h5, 1'b0, c[2:0]});
      rd(ADCSEQ_OFF_STAT, 8'h01);
      wr(ADCSEQ_OFF_MASK, 8'h00);
      nap(2);
      chkb(irq_o, 1'b0);
      wr(ADCSEQ_OFF_MASK, 8'h01);
      nap(2);
      chkb(irq_o, 1'b1);
      wr(ADCSEQ_OFF_STAT, 8'h01);
      nap(2);
      chkb(irq_o, 1'b0);
      rd(ADCSEQ_OFF_STAT, 8'h00);
      $display("test divider %0d done", c);
    end
    wr(ADCSEQ_OFF_CTRL0, 8'h00);
    nap(2);
    chkb(ana_power_o, 1'b0);
    $display("test power down done");
    end_sim();
  end
endmodule : tb_adcseq_top
`default_nettype wire
